// >>> hdl/prb_map.vh
/*
 * Offsets, fields, reset values and codes of the render back end.
 * Assumes inclusion by bare name.
 */
`ifndef PRB_MAP_VH
`define PRB_MAP_VH
// Byte offsets
`define PRB_REG_TEX   8'h00
`define PRB_REG_PIX   8'h04
`define PRB_REG_FGBG  8'h08
`define PRB_REG_KEY   8'h0C
`define PRB_REG_LINE  8'h10
`define PRB_REG_DASH  8'h14
`define PRB_REG_STAT  8'h18
// TEX fields
`define PRB_TX_SLOG   0
`define PRB_TX_TLOG   4
`define PRB_TX_WRAP   8
`define PRB_TX_BIL    10
`define PRB_TX_PERSP  11
`define PRB_TX_BLEND  12
`define PRB_TX_FAST   14
`define PRB_TX_MODE   15
`define PRB_TX_TEX8   17
// PIX fields
`define PRB_PX_ALPHA  0
`define PRB_PX_AMODE  8
`define PRB_PX_AEN    10
`define PRB_PX_ROP    11
`define PRB_PX_ROPEN  15
`define PRB_PX_TRSP   16
`define PRB_PX_BGTR   17
`define PRB_PX_BMFMT  18
`define PRB_PX_ZCMP   20
`define PRB_PX_ZEN    23
`define PRB_PX_ZINH   24
`define PRB_PX_Z8     25
`define PRB_PX_FB16   26
// Reset values
`define PRB_RST_TEX   32'h0000_0022
`define PRB_RST_PIX   32'h0400_1800
`define PRB_RST_LINE  32'h0000_0000
`define PRB_RST_DASH  32'hFFFF_FFFF
// Codings
`define PRB_WRAP_REP  2'h0
`define PRB_WRAP_CLMP 2'h1
`define PRB_WRAP_BRD  2'h2
`define PRB_BL_DECAL  2'h0
`define PRB_BL_MOD    2'h1
`define PRB_BL_STEN   2'h2
`define PRB_TM_TEX    2'h1
`define PRB_TM_TILE   2'h2
`define PRB_AM_NORM   2'h0
`define PRB_AM_STEN   2'h1
`define PRB_AM_STAL   2'h2
`define PRB_BM_8      2'h0
`define PRB_BM_16     2'h1
`define PRB_BM_1      2'h2
`define PRB_K_POLY    2'h0
`define PRB_K_BLT     2'h1
`define PRB_K_BMAP    2'h2
`define PRB_K_LINE    2'h3
`define PRB_LOG_MIN   4'h2
`define PRB_LOG_MAX   4'hC
`define PRB_TILE_MAX  4'h6
`endif

// >>> hdl/prb_pixel_render_backend.v
/*
 * Pixel render back end: tile or texture fetch, texture blend, depth test,
 * alpha blend or raster logic, frame and depth write. AXI4-Lite registers.
 * Assumes the rasteriser supplies each pixel with stored frame and depth
 * values, and texture memory answers each texel request.
 */
// Decided for this implementation: the address map and the AXI4-Lite register port.
// Functional notes
// [R01] Block transfer: logic op, skip transparent color
// [R02] Bitmap formats 8, 16 and 1 bpp
// [R03] 1bpp: fg for 1, bg or skip for 0
// [R04] Texture sizes powers of two 4..4096
// [R05] 8-bit textures: point sampling, decal only
// [R06] Repeat wrap keeps log2(size) low bits
// [R07] Clamp wrap to 0 and size-1
// [R08] Border wrap gives border color outside
// [R09] Point filter uses nearest texel unchanged
// [R10] Bilinear weights four nearest texels
// [R11] Perspective correction with Q equal 1/W
// [R12] Texture blend decal, modulate, stencil
// [R13] Fast bilinear: bilinear, repeat, 16-bit only
// [R14] Tiling by pixel coords, 64x64 max
// [R15] Alpha C = Cp*A + (1-A)*Cf, 8-bit
// [R16] Alpha only 16bpp, never with logic ops
// [R17] Alpha modes normal, stencil, stencil-alpha
// [R18] Stencil modes write texel MSB to frame
// [R19] Four-bit raster logic code on source/frame
// [R20] Three-bit depth compare code
// [R21] Depth write inhibit, 16 or 8 bit depth
// [R22] Line width 1..32, dash pattern, anti-alias; the width bits are stored in LINE but never applied
// [R23] Fixed per-pixel stage order
`timescale 1ns/1ps
`include "prb_map.vh"
module prb_pixel_render_backend (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pixValid,
  output wire        pixReady,
  input  wire [1:0]  pixKind,
  input  wire [11:0] pixX,
  input  wire [11:0] pixY,
  input  wire [13:0] pixS,
  input  wire [13:0] pixT,
  input  wire [3:0]  pixSFrac,
  input  wire [3:0]  pixTFrac,
  input  wire [15:0] pixW,
  input  wire [15:0] pixColor,
  input  wire        pixBit,
  input  wire [15:0] pixDst,
  input  wire [15:0] pixDstZ,
  input  wire [15:0] pixZ,
  input  wire [4:0]  pixDashIdx,
  input  wire [7:0]  pixCov,
  output wire        texReqValid,
  output reg  [11:0] texS0_q,
  output reg  [11:0] texT0_q,
  output reg  [11:0] texS1_q,
  output reg  [11:0] texT1_q,
  output reg         texFast_q,
  input  wire        texDataValid,
  input  wire [63:0] texData,
  output reg         outValid_q,
  output reg  [11:0] outX_q,
  output reg  [11:0] outY_q,
  output reg         fbWe_q,
  output reg  [15:0] fbData_q,
  output reg         zWe_q,
  output reg  [15:0] zData_q
);
  localparam [2:0] ST_IDLE = 3'h1, ST_FETCH = 3'h2, ST_WRITE = 3'h4;

  reg [31:0] texReg_q, pixReg_q, fgbgReg_q, keyReg_q, lineReg_q, dashReg_q;
  reg [2:0]  state_q;
  reg [15:0] count_q;
  reg        awHeld_q, wHeld_q;
  reg [7:0]  awAddr_q;
  reg [31:0] wData_q;
  reg [3:0]  wStrb_q;
  reg [1:0]  kind_q;
  reg [11:0] x_q, y_q;
  reg [3:0]  sf_q, tf_q;
  reg [3:0]  brd_q;
  reg [15:0] col_q, dst_q, dstZ_q, z_q;
  reg        bit_q, dash_q;
  reg [7:0]  cov_q;
  reg [63:0] texel_q;

  // Clamp a size exponent
  function [3:0] clog;
    input [3:0] lg;
    begin
      clog = (lg < `PRB_LOG_MIN) ? `PRB_LOG_MIN : ((lg > `PRB_LOG_MAX) ? `PRB_LOG_MAX : lg); // [R04]
    end
  endfunction

  // Wrap a signed coordinate
  function [11:0] wrapc;
    input [13:0] c;
    input [3:0]  lg;
    input [1:0]  m;
    reg   [12:0] sz;
    begin
      sz = 13'h0001 << clog(lg);
      if (m == `PRB_WRAP_CLMP) begin
        if (c[13]) wrapc = 12'h000; // [R07]
        else if (c[12:0] > sz - 13'h0001) wrapc = sz[11:0] - 12'h001; // [R07]
        else wrapc = c[11:0];
      end else begin
        wrapc = c[11:0] & (sz[11:0] - 12'h001); // [R06]
      end
    end
  endfunction

  // Outside the pattern
  function outside;
    input [13:0] c;
    input [3:0]  lg;
    reg   [12:0] sz;
    begin
      sz = 13'h0001 << clog(lg);
      outside = c[13] | (c[12:0] >= sz); // [R08]
    end
  endfunction

  // Mix two 1-5-5-5 colors, weight 0..256 toward b
  function [15:0] mix16;
    input [15:0] a;
    input [15:0] b;
    input [8:0]  w;
    reg   [14:0] t0, t1, t2;
    begin
      t0 = a[4:0] * (9'h100 - w) + b[4:0] * w;
      t1 = a[9:5] * (9'h100 - w) + b[9:5] * w;
      t2 = a[14:10] * (9'h100 - w) + b[14:10] * w;
      mix16 = {a[15], t2[12:8], t1[12:8], t0[12:8]};
    end
  endfunction

  // Texel times polygon color
  function [15:0] mod16;
    input [15:0] t;
    input [15:0] p;
    reg   [10:0] m0, m1, m2;
    begin
      m0 = t[4:0] * ({1'b0, p[4:0]} + 6'h01);
      m1 = t[9:5] * ({1'b0, p[9:5]} + 6'h01);
      m2 = t[14:10] * ({1'b0, p[14:10]} + 6'h01);
      mod16 = {t[15], m2[9:5], m1[9:5], m0[9:5]}; // [R12]
    end
  endfunction

  // Raster logic, code bit {!s,!d}
  function [15:0] rop16;
    input [3:0]  code;
    input [15:0] s;
    input [15:0] d;
    integer i;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        rop16[i] = code[{~s[i], ~d[i]}]; // [R19]
      end
    end
  endfunction

  // Depth compare, new against stored
  function zcmp;
    input [2:0]  code;
    input [15:0] n;
    input [15:0] o;
    begin
      case (code) // [R20]
        3'h0:    zcmp = 1'b0;
        3'h1:    zcmp = 1'b1;
        3'h2:    zcmp = n < o;
        3'h3:    zcmp = n <= o;
        3'h4:    zcmp = n == o;
        3'h5:    zcmp = n >= o;
        3'h6:    zcmp = n > o;
        default: zcmp = n != o;
      endcase
    end
  endfunction

  // Byte-lane write merge
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  st;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wmerge[i*8 +: 8] = st[i] ? d[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // Decoded controls
  wire [3:0]  sLog    = texReg_q[`PRB_TX_SLOG +: 4];
  wire [3:0]  tLog    = texReg_q[`PRB_TX_TLOG +: 4];
  wire [1:0]  wrapM   = texReg_q[`PRB_TX_WRAP +: 2];
  wire        tex8    = texReg_q[`PRB_TX_TEX8];
  wire [1:0]  texMode = texReg_q[`PRB_TX_MODE +: 2];
  wire        tileOn  = texMode == `PRB_TM_TILE; // [R14]
  wire        texOn   = texMode == `PRB_TM_TEX;
  wire        bilOn   = texReg_q[`PRB_TX_BIL] & ~tex8 & texOn; // [R05]
  wire [1:0]  blendM  = tex8 ? `PRB_BL_DECAL : texReg_q[`PRB_TX_BLEND +: 2]; // [R05]
  wire        fastOn  = texReg_q[`PRB_TX_FAST] & bilOn & (wrapM == `PRB_WRAP_REP); // [R13]
  wire [1:0]  bmFmt   = pixReg_q[`PRB_PX_BMFMT +: 2];
  wire        fb16    = pixReg_q[`PRB_PX_FB16];
  wire        ropEn   = pixReg_q[`PRB_PX_ROPEN];
  wire        alphaEn = pixReg_q[`PRB_PX_AEN] & fb16 & ~ropEn; // [R16]
  wire [1:0]  aMode   = pixReg_q[`PRB_PX_AMODE +: 2];
  wire        zEn     = pixReg_q[`PRB_PX_ZEN];
  wire        z8      = pixReg_q[`PRB_PX_Z8];
  wire        cfgErr  = (pixReg_q[`PRB_PX_AEN] & ropEn) | (texReg_q[`PRB_TX_FAST] & ~fastOn);
  wire        lineAa  = lineReg_q[5];
  wire        grayGouraudEnable = lineReg_q[6];
  wire        texNeed = (pixKind == `PRB_K_POLY) & (texOn | tileOn);

  // Perspective: coordinate times W
  wire signed [30:0] sProd = $signed(pixS) * $signed({1'b0, pixW});
  wire signed [30:0] tProd = $signed(pixT) * $signed({1'b0, pixW});
  wire        perspOn = texReg_q[`PRB_TX_PERSP];
  wire [13:0] sCor = perspOn ? sProd[21:8] : pixS; // [R11]
  wire [13:0] tCor = perspOn ? tProd[21:8] : pixT; // [R11]
  wire [13:0] sNext = sCor + 14'h0001;
  wire [13:0] tNext = tCor + 14'h0001;
  wire [3:0]  tileS = (clog(sLog) > `PRB_TILE_MAX) ? `PRB_TILE_MAX : sLog;
  wire [3:0]  tileT = (clog(tLog) > `PRB_TILE_MAX) ? `PRB_TILE_MAX : tLog;

  assign pixReady    = state_q == ST_IDLE;
  assign texReqValid = state_q == ST_FETCH;

  // Ready outputs
  assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Register writes and reads
  always @(posedge clk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      texReg_q <= `PRB_RST_TEX;
      pixReg_q <= `PRB_RST_PIX;
      fgbgReg_q <= 32'h0000_0000;
      keyReg_q <= 32'h0000_0000;
      lineReg_q <= `PRB_RST_LINE;
      dashReg_q <= `PRB_RST_DASH;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (awHeld_q & wHeld_q) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case ({awAddr_q[7:2], 2'h0})
          `PRB_REG_TEX:  texReg_q <= wmerge(texReg_q, wData_q, wStrb_q);
          `PRB_REG_PIX:  pixReg_q <= wmerge(pixReg_q, wData_q, wStrb_q);
          `PRB_REG_FGBG: fgbgReg_q <= wmerge(fgbgReg_q, wData_q, wStrb_q);
          `PRB_REG_KEY:  keyReg_q <= wmerge(keyReg_q, wData_q, wStrb_q);
          `PRB_REG_LINE: lineReg_q <= wmerge(lineReg_q, wData_q, wStrb_q) & 32'h0000_007F;
          `PRB_REG_DASH: dashReg_q <= wmerge(dashReg_q, wData_q, wStrb_q);
          `PRB_REG_STAT: s_axi_bresp <= 2'h0;
          default:       s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[7:2], 2'h0})
          `PRB_REG_TEX:  s_axi_rdata <= texReg_q;
          `PRB_REG_PIX:  s_axi_rdata <= pixReg_q;
          `PRB_REG_FGBG: s_axi_rdata <= fgbgReg_q;
          `PRB_REG_KEY:  s_axi_rdata <= keyReg_q;
          `PRB_REG_LINE: s_axi_rdata <= lineReg_q;
          `PRB_REG_DASH: s_axi_rdata <= dashReg_q;
          `PRB_REG_STAT: s_axi_rdata <= {count_q, 12'h000, cfgErr, state_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Border color outside the pattern
  wire [15:0] bord = keyReg_q[31:16];
  wire [15:0] tx0 = brd_q[0] ? bord : texel_q[15:0]; // [R08]
  wire [15:0] tx1 = brd_q[1] ? bord : texel_q[31:16];
  wire [15:0] tx2 = brd_q[2] ? bord : texel_q[47:32];
  wire [15:0] tx3 = brd_q[3] ? bord : texel_q[63:48];
  wire [8:0]  wS = {1'b0, sf_q, sf_q};
  wire [8:0]  wT = {1'b0, tf_q, tf_q};
  wire [15:0] bilC = mix16(mix16(tx0, tx1, wS), mix16(tx2, tx3, wS), wT); // [R10]
  wire [15:0] pointC = tex8 ? {8'h00, tx0[7:0]} : tx0; // [R09]
  wire [15:0] texC = bilOn ? bilC : pointC;

  // Per-pixel stages in fixed order
  reg [15:0] src, res, mixA;
  reg        skip, pass, texUsed;
  reg [8:0]  aW;
  always @* begin
    texUsed = 1'b0;
    skip = 1'b0;
    src = col_q;
    case (kind_q)
      `PRB_K_POLY: begin
        if (tileOn) begin
          src = texC; // [R14]
        end else if (texOn) begin
          texUsed = 1'b1;
          case (blendM) // [R12]
            `PRB_BL_MOD:  src = mod16(texC, col_q);
            `PRB_BL_STEN: src = texC[15] ? texC : col_q;
            default:      src = texC;
          endcase
        end else if (grayGouraudEnable & ~fb16) begin
          src = {8'h00, col_q[7:0]};
        end
      end
      `PRB_K_BLT: skip = pixReg_q[`PRB_PX_TRSP] & (col_q == keyReg_q[15:0]); // [R01]
      `PRB_K_BMAP: begin
        case (bmFmt) // [R02]
          `PRB_BM_1: begin
            src = bit_q ? fgbgReg_q[15:0] : fgbgReg_q[31:16]; // [R03]
            skip = ~bit_q & pixReg_q[`PRB_PX_BGTR]; // [R03]
          end
          `PRB_BM_8: src = {8'h00, col_q[7:0]};
          default:   src = col_q;
        endcase
      end
      default: skip = ~dash_q; // [R22]
    endcase
    pass = ~zEn | (z8 ? zcmp(pixReg_q[`PRB_PX_ZCMP +: 3], {8'h00, z_q[7:0]}, {8'h00, dstZ_q[7:0]})
                      : zcmp(pixReg_q[`PRB_PX_ZCMP +: 3], z_q, dstZ_q)); // [R20]
    aW = {1'b0, pixReg_q[`PRB_PX_ALPHA +: 8]} + {8'h00, pixReg_q[`PRB_PX_ALPHA + 7]}; // [R15]
    mixA = mix16(dst_q, src, aW);
    res = src;
    if ((kind_q == `PRB_K_LINE) & lineAa) begin
      res = mix16(dst_q, src, {1'b0, cov_q} + {8'h00, cov_q[7]}); // [R22]
    end else if (alphaEn) begin
      if (texUsed & (aMode == `PRB_AM_STEN)) begin
        res = texC[15] ? src : {texC[15], dst_q[14:0]}; // [R17] [R18]
      end else if (texUsed & (aMode == `PRB_AM_STAL)) begin
        res = texC[15] ? {1'b1, mixA[14:0]} : {1'b0, dst_q[14:0]}; // [R17] [R18]
      end else begin
        res = mixA; // [R15] [R17]
      end
    end else if (ropEn) begin
      res = rop16(pixReg_q[`PRB_PX_ROP +: 4], src, dst_q); // [R01] [R19]
    end
  end

  // Sequencer and outputs
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      count_q <= 16'h0000;
      kind_q <= 2'h0;
      x_q <= 12'h000;
      y_q <= 12'h000;
      sf_q <= 4'h0;
      tf_q <= 4'h0;
      brd_q <= 4'h0;
      col_q <= 16'h0000;
      dst_q <= 16'h0000;
      dstZ_q <= 16'h0000;
      z_q <= 16'h0000;
      bit_q <= 1'b0;
      dash_q <= 1'b0;
      cov_q <= 8'h00;
      texel_q <= 64'h0;
      texS0_q <= 12'h000;
      texT0_q <= 12'h000;
      texS1_q <= 12'h000;
      texT1_q <= 12'h000;
      texFast_q <= 1'b0;
      outValid_q <= 1'b0;
      outX_q <= 12'h000;
      outY_q <= 12'h000;
      fbWe_q <= 1'b0;
      fbData_q <= 16'h0000;
      zWe_q <= 1'b0;
      zData_q <= 16'h0000;
    end else begin
      outValid_q <= 1'b0;
      fbWe_q <= 1'b0;
      zWe_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (pixValid) begin
            kind_q <= pixKind;
            x_q <= pixX;
            y_q <= pixY;
            col_q <= pixColor;
            dst_q <= pixDst;
            dstZ_q <= pixDstZ;
            z_q <= pixZ;
            bit_q <= pixBit;
            dash_q <= dashReg_q[pixDashIdx];
            cov_q <= pixCov;
            sf_q <= tileOn ? 4'h0 : pixSFrac;
            tf_q <= tileOn ? 4'h0 : pixTFrac;
            texFast_q <= fastOn; // [R13]
            if (tileOn) begin
              texS0_q <= wrapc({2'h0, pixX}, tileS, `PRB_WRAP_REP); // [R14]
              texT0_q <= wrapc({2'h0, pixY}, tileT, `PRB_WRAP_REP); // [R14]
              brd_q <= 4'h0;
            end else begin
              texS0_q <= wrapc(sCor, sLog, wrapM);
              texT0_q <= wrapc(tCor, tLog, wrapM);
              texS1_q <= wrapc(sNext, sLog, wrapM);
              texT1_q <= wrapc(tNext, tLog, wrapM);
              brd_q <= (wrapM == `PRB_WRAP_BRD) ? // [R08]
                {outside(sNext, sLog) | outside(tNext, tLog), outside(sCor, sLog) |
                 outside(tNext, tLog), outside(sNext, sLog) | outside(tCor, tLog),
                 outside(sCor, sLog) | outside(tCor, tLog)} : 4'h0;
            end
            state_q <= texNeed ? ST_FETCH : ST_WRITE; // [R23]
          end
        end
        ST_FETCH: begin
          if (texDataValid) begin
            texel_q <= texData;
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          outValid_q <= 1'b1;
          outX_q <= x_q;
          outY_q <= y_q;
          fbData_q <= fb16 ? res : {8'h00, res[7:0]};
          fbWe_q <= ~skip & pass; // [R23]
          zWe_q <= ~skip & pass & zEn & ~pixReg_q[`PRB_PX_ZINH]; // [R21]
          zData_q <= z8 ? {8'h00, z_q[7:0]} : z_q; // [R21]
          if (~skip & pass) count_q <= count_q + 16'h0001;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // prb_pixel_render_backend

// >>> sim/prb_pixel_render_backend_chk.sv
/* Checker: handshake and pipeline timing of the render back end.
   Assumes a bind to the top module; sees only its ports. */
`timescale 1ns/1ps
module prb_pixel_render_backend_chk (
  input wire        clk,
  input wire        rst,
  input wire        s_axi_arready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        pixValid,
  input wire        pixReady,
  input wire [1:0]  pixKind,
  input wire        texReqValid,
  input wire        texDataValid,
  input wire        outValid_q,
  input wire        fbWe_q,
  input wire        zWe_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Pixel taken, texels arrived
  sequence sTake; pixValid && pixReady && pixKind != 2'h0; endsequence
  sequence sTexDone; texReqValid && texDataValid; endsequence
  a_pix_latency: assert property (sTake |-> ##2 outValid_q)
    else $error("late result");
  a_tex_latency: assert property (sTexDone |-> ##2 outValid_q)
    else $error("late textured result");
  a_busy_refuse: assert property (pixValid && pixReady |=> !pixReady)
    else $error("accepted while busy");
  a_out_pulse: assert property (outValid_q |=> !outValid_q)
    else $error("long result strobe");
  a_we_qualified: assert property (fbWe_q || zWe_q |-> outValid_q)
    else $error("stray write");
  a_tex_wait: assert property (texReqValid && !texDataValid |=> texReqValid)
    else $error("texel request dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule // prb_pixel_render_backend_chk

// >>> sim/prb_tex_mem_model.sv
/* Texture memory model: texels a set delay after each request.
   Assumes one request at a time; data toggles while idle. */
`timescale 1ns/1ps
module prb_tex_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  delay,
  input  wire logic        texReqValid,
  input  wire logic [11:0] texS0_q,
  input  wire logic [11:0] texT0_q,
  input  wire logic [11:0] texS1_q,
  input  wire logic [11:0] texT1_q,
  output logic             texDataValid,
  output logic [63:0]      texData
);
  logic [7:0] cnt_q;
  function automatic logic [15:0] texel(input logic [11:0] s, t);
    return {t[5:0], s[9:0]};
  endfunction
  // Pulse four texels after the delay
  always @(posedge clk) begin
    texDataValid <= 1'b0;
    texData      <= rst ? 64'h0 : ~texData;
    if (rst) cnt_q <= 8'h00;
    else if (texReqValid && !texDataValid) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == delay) begin
        cnt_q        <= 8'h00;
        texDataValid <= 1'b1;
        texData      <= {texel(texS1_q, texT1_q), texel(texS0_q, texT1_q),
                         texel(texS1_q, texT0_q), texel(texS0_q, texT0_q)};
      end
    end
  end
endmodule // prb_tex_mem_model

// >>> sim/prb_pixel_render_backend_tb.sv
/* Self-checking bench for the pixel render back end.
   Assumes the texture model and the checker beside it. */
`timescale 1ns/1ps
`include "prb_map.vh"
module prb_pixel_render_backend_tb;
  logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pixValid;
  logic pixReady, pixBit, texReqValid, texFast_q, texDataValid, outValid_q, fbWe_q, zWe_q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pixKind;
  logic [3:0]  s_axi_wstrb, pixSFrac, pixTFrac;
  logic [4:0]  pixDashIdx;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pixCov, delay;
  logic [11:0] pixX, pixY, texS0_q, texT0_q, texS1_q, texT1_q, outX_q, outY_q;
  logic [13:0] pixS, pixT;
  logic [15:0] pixW, pixColor, pixDst, pixDstZ, pixZ, fbData_q, zData_q, zn, zo;
  logic [31:0] s_axi_wdata, s_axi_rdata, a, rs = 34;
  logic [63:0] texData;
  logic [34:0] expQ[$], e, f;
  logic [31:0] av[4] = '{32'h0400_0400, 32'h0400_04FF, 32'h0400_9C00, 32'h0000_0400};
  int          n_errors = 0, checks_done = 0, i;
  prb_pixel_render_backend u_dut (.*);
  prb_tex_mem_model u_tex (.*);
  function automatic logic [31:0] rnd();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [15:0] rop(input [3:0] c, input [15:0] s, d);
    for (int k = 0; k < 16; k++) rop[k] = c[{~s[k], ~d[k]}];
  endfunction
  function automatic logic zpass(input [2:0] c, input [15:0] n, o);
    logic [7:0] r;
    r = {n != o, n > o, n >= o, n == o, n <= o, n < o, 1'b1, 1'b0};
    return r[c];
  endfunction
  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic guard(input int n);
    if (n > 500) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic wr(input [7:0] ad, input [31:0] d, input [3:0] sb = 4'hF, input [1:0] er = 0);
    int n;
    s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_wstrb <= sb; n = 0;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk); n++; guard(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0; @(posedge clk);
  endtask
  task automatic rd(input [7:0] ad, input [31:0] ed, input [1:0] er = 0);
    int n;
    s_axi_araddr <= ad; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1; n = 0;
    do begin
      @(posedge clk); n++; guard(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata, ed); chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0; @(posedge clk);
  endtask
  // Offer a pixel and note its result
  task automatic px(input [1:0] k, input [15:0] c, d, input [34:0] ex, input [15:0] z = 0,
                    dz = 0, input b = 0, input [13:0] s = 0, t = 0, input [11:0] x = 0, y = 0);
    int n;
    logic [31:0] r;
    r = rnd(); n = 0; expQ.push_back(ex);
    pixKind <= k; pixColor <= c; pixDst <= d; pixZ <= z; pixDstZ <= dz; pixBit <= b;
    pixS <= s; pixT <= t; pixX <= x; pixY <= y; pixValid <= 1'b1;
    pixW <= r[15:0]; pixCov <= r[23:16]; pixDashIdx <= r[28:24];
    do begin @(posedge clk); n++; guard(n); end while (!pixReady);
  endtask
  task automatic drain;
    int n;
    pixValid <= 1'b0; n = 0;
    do begin @(posedge clk); n++; guard(n); end while (expQ.size() != 0);
  endtask
  task automatic tc(input [31:0] cfg, input [13:0] s, t, input [15:0] ex, input [11:0] x = 0, y = 0);
    wr(`PRB_REG_TEX, cfg);
    px(2'h0, 16'h0155, 16'h0F0F, {19'h1, ex}, 0, 0, 0, s, t, x, y);
    drain;
  endtask
  // Oldest note against each result
  always @(posedge clk) if (outValid_q) begin
    if (expQ.size() == 0) chk("extra", 1, 0);
    else begin
      f = expQ.pop_front();
      chk("fbWe", fbWe_q, f[16]);
      if (f[16]) chk("fbData", fbData_q, f[15:0]);
      if (f[34]) chk("zWe", zWe_q, f[33]);
      if (f[34] && f[33]) chk("zData", zData_q, f[32:17]);
    end
  end
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Main sequence
  initial begin
    rst = 1'b1; s_axi_awvalid = 0; s_axi_wvalid = 0; s_axi_bready = 0; s_axi_arvalid = 0;
    s_axi_rready = 0; s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 0;
    {pixValid, pixKind, pixX, pixY, pixS, pixT, pixW, pixColor, pixBit} = '0;
    {pixDst, pixDstZ, pixZ, pixDashIdx, pixCov, pixSFrac, pixTFrac, delay} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`PRB_REG_TEX, 32'h0000_0022);
    rd(`PRB_REG_PIX, 32'h0400_1800);
    rd(`PRB_REG_DASH, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0, 2'h2);
    wr(8'h1C, 32'h0, 4'hF, 2'h2);
    wr(`PRB_REG_PIX, 32'hFFFF_FF5A, 4'h1);
    rd(`PRB_REG_PIX, 32'h0400_185A);
    for (i = 0; i < 16; i++) begin
      a = rnd();
      wr(`PRB_REG_PIX, 32'h0400_8000 | (i << 11));
      px(2'h1, a[15:0], a[31:16], {19'h1, rop(4'(i), a[15:0], a[31:16])});
      drain;
    end
    wr(`PRB_REG_KEY, 32'h7C00_2A2A);
    wr(`PRB_REG_PIX, 32'h0401_9800);
    px(2'h1, 16'h2A2A, 16'h5555, 35'h0);
    px(2'h1, 16'h2A2B, 16'h5555, {19'h1, 16'h2A2B});
    drain;
    wr(`PRB_REG_FGBG, 32'h1111_7E0F);
    for (i = 0; i < 12; i++) begin
      a = rnd();
      wr(`PRB_REG_PIX, 32'h0400_0000 | ((i % 3) << 18) | (((i / 3) & 1) << 17));
      if (i % 3 != 2) e = {19'h1, (i % 3) ? a[15:8] : 8'h00, a[7:0]};
      else if (i >= 6) e = {19'h1, 16'h7E0F};
      else e = ((i / 3) & 1) ? 35'h0 : {19'h1, 16'h1111};
      px(2'h2, a[15:0], a[31:16], e, 0, 0, i >= 6);
      drain;
    end
    for (i = 0; i < 24; i++) begin
      a = rnd(); zn = {4'h4, a[27:16]}; zo = zn + 16'(i % 3) - 16'h1;
      wr(`PRB_REG_PIX, 32'h0480_0000 | ((i / 3) << 20) | ((i & 1) << 24));
      e[34:16] = {1'b1, zpass(3'(i / 3), zn, zo) & ~i[0], zn, zpass(3'(i / 3), zn, zo)};
      px(2'h0, a[15:0], ~a[15:0], {e[34:16], a[15:0]}, zn, zo);
      drain;
    end
    for (i = 0; i < 4; i++) begin
      a = rnd();
      wr(`PRB_REG_PIX, av[i]);
      e = {19'h1, i == 0 ? a[31:16] : i == 1 ? {a[31], a[14:0]} : i == 2 ? a[15:0]
           : {8'h00, a[7:0]}};
      px(2'h0, a[15:0], a[31:16], e);
      drain;
    end
    wr(`PRB_REG_PIX, 32'h0400_1800);
    tc(32'h0000_8066, 14'd70, -14'sd30, {6'd34, 10'd6});
    tc(32'h0000_8166, -14'sd5, 14'd100, {6'd63, 10'd0});
    delay <= 8'd4;
    tc(32'h0000_8166, 14'd63, 14'd64, {6'd63, 10'd63});
    tc(32'h0000_8266, -14'sd1, 14'd5, 16'h7C00);
    tc(32'h0000_A066, 14'd1, 14'd32, {6'd32, 10'd1});
    tc(32'h0000_A066, 14'd1, 14'd1, 16'h0155);
    tc(32'h0001_0066, 14'd0, 14'd0, {6'd6, 10'd2}, 12'd130, 12'd70);
    print_verdict();
  end
endmodule // prb_pixel_render_backend_tb
bind prb_pixel_render_backend prb_pixel_render_backend_chk u_chk (.clk, .rst, .s_axi_arready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pixValid,
  .pixReady, .pixKind, .texReqValid, .texDataValid, .outValid_q, .fbWe_q, .zWe_q);
